// File: design/cmt_consts.svh
// Named constants for the period timer
`ifndef CMT_CONSTS_SVH
`define CMT_CONSTS_SVH
`define CMT_ZERO16    16'h0000
`define CMT_ONE16     16'h0001
`define CMT_CNT_MAX   16'hFFFF
`define CMT_UPR_RST   16'hFFFF
`define CMT_ZERO8     8'h00
`define CMT_PAD16     16'h0000
`define CMT_PAD24     24'h000000
`define CMT_MAP_HI    3'h0
`define CMT_IDX_CNT   3'h0
`define CMT_IDX_UPR   3'h1
`define CMT_IDX_LWR   3'h2
`define CMT_IDX_CAP   3'h3
`define CMT_IDX_BUF   3'h4
`define CMT_IDX_STS   3'h5
`define CMT_IDX_CTL   3'h6
`define CMT_IDX_IEN   3'h7
`define CMT_RESP_OK   2'h0
`define CMT_RESP_ERR  2'h2
`define CMT_B_RUN     7
`define CMT_B_INV     6
`define CMT_B_HALT    5
`define CMT_B_EDGE    4
`define CMT_B_MODE    3
`define CMT_B_WRAP    7
`define CMT_B_ABOVE   6
`define CMT_B_MATCH   5
`define CMT_B_EXTEDGE 4
`define CMT_B_PINEN   4
`define CMT_B_CAPF    3
`define CMT_B_BELOW   2
`define CMT_B_GLVL    1
`define CMT_B_GATE    1
`define CMT_B_RSV     0
`define CMT_FLAG_MASK 8'hEC
`define CMT_STS_CFG   8'h12
`define CMT_IEN_MASK  8'hFE
`define CMT_CKS_EXT   3'h7
`define CMT_DIV2      8'h01
`define CMT_DIV8      8'h07
`define CMT_DIV16     8'h0F
`define CMT_DIV32     8'h1F
`define CMT_DIV64     8'h3F
`define CMT_DIV128    8'h7F
`define CMT_DIV256    8'hFF
`endif

// File: design/cmt_event_in.sv
// Event and gate pin synchronisers with active edge selection
`default_nettype none
`include "cmt_consts.svh"
module cmt_event_in
	import cmt_pkg::*;
(
	input  wire logic aclk,       // System clock
	input  wire logic aresetn,    // Synchronous reset, active low
	input  wire logic event_pin,  // Measured event pin
	input  wire logic gate_pin,   // Measurement gate pin
	cmt_tick_if.edg   tif         // Edge settings in, pulses out
);
	logic ev_s1_reg;
	logic ev_s2_reg;
	logic ev_s3_reg;
	logic gt_s1_reg;
	logic gt_s2_reg;
	logic edge_reg;
	logic gate_reg;
	logic fall_sel;

	assign fall_sel = tif.edge_sel ^ tif.event_invert; // R2

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_s1_reg <= 1'b0;
			ev_s2_reg <= 1'b0;
			ev_s3_reg <= 1'b0;
			gt_s1_reg <= 1'b0;
			gt_s2_reg <= 1'b0;
		end else begin
			ev_s1_reg <= event_pin;
			ev_s2_reg <= ev_s1_reg;
			ev_s3_reg <= ev_s2_reg;
			gt_s1_reg <= gate_pin;
			gt_s2_reg <= gt_s1_reg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			edge_reg <= 1'b0;
			gate_reg <= 1'b1;
		end else begin
			edge_reg <= tif.event_pin_en & (fall_sel // R7 R2
				? (~ev_s2_reg & ev_s3_reg) : (ev_s2_reg & ~ev_s3_reg));
			gate_reg <= ~tif.gate_use_en // R8
				| (gt_s2_reg == tif.gate_level_sel);
		end
	end

	assign tif.event_edge = edge_reg;
	assign tif.gate_ok    = gate_reg;
endmodule // cmt_event_in
`default_nettype wire

// File: design/cmt_pkg.sv
// Types shared by the period timer modules
`default_nettype none
package cmt_pkg;
	typedef enum logic [1:0] {PH_WAIT, PH_RUN, PH_HOLD} cmt_phase_t;
	typedef logic [15:0] cmt_word_t;
endpackage
`default_nettype wire

// File: design/cmt_prescale.sv
// Count clock source: system clock divider or synchronised external clock
`default_nettype none
`include "cmt_consts.svh"
module cmt_prescale
	import cmt_pkg::*;
(
	input  wire logic aclk,        // System clock
	input  wire logic aresetn,     // Synchronous reset, active low
	input  wire logic ext_clk_pin, // External count clock pin
	cmt_tick_if.pre   tif          // Clock select in, tick out
);
	logic [7:0] div_reg;
	logic [7:0] mask;
	logic       ext_s1_reg;
	logic       ext_s2_reg;
	logic       ext_s3_reg;
	logic       tick_reg;

	always_comb begin
		unique case (tif.clk_sel)
			3'h0: mask = `CMT_DIV2;
			3'h1: mask = `CMT_DIV8;
			3'h2: mask = `CMT_DIV16;
			3'h3: mask = `CMT_DIV32;
			3'h4: mask = `CMT_DIV64;
			3'h5: mask = `CMT_DIV128;
			3'h6: mask = `CMT_DIV256;
			3'h7: mask = `CMT_ZERO8;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= `CMT_ZERO8;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end else begin
			ext_s1_reg <= ext_clk_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	// One tick per selected source period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_reg <= 1'b0;
		end else if (tif.clk_sel == `CMT_CKS_EXT) begin
			tick_reg <= tif.ext_edge_sel ? (ext_s2_reg & ~ext_s3_reg) // R4
				: (~ext_s2_reg & ext_s3_reg);
		end else begin
			tick_reg <= (div_reg & mask) == mask; // R4
		end
	end

	assign tif.count_tick = tick_reg;
endmodule // cmt_prescale
`default_nettype wire

// File: design/cmt_tick_if.sv
// Settings and event pulses between the timer core and its front ends
`default_nettype none
interface cmt_tick_if;
	logic [2:0] clk_sel;
	logic       ext_edge_sel;
	logic       count_tick;
	logic       edge_sel;
	logic       event_invert;
	logic       event_pin_en;
	logic       gate_use_en;
	logic       gate_level_sel;
	logic       event_edge;
	logic       gate_ok;
	modport core (output clk_sel, ext_edge_sel, edge_sel, event_invert,
		event_pin_en, gate_use_en, gate_level_sel,
		input count_tick, event_edge, gate_ok);
	modport pre (input clk_sel, ext_edge_sel, output count_tick);
	modport edg (input edge_sel, event_invert, event_pin_en, gate_use_en,
		gate_level_sel, output event_edge, gate_ok);
endinterface
`default_nettype wire

// File: design/cmt_top.sv
// Period timer top: register slave, counter, capture and limit checks
`default_nettype none
`include "cmt_consts.svh"
// What this block does
// R1: Measure mode with halt enabled: a limit flag stops counting and capture.
// R2: Active event edge is edge_sel, reversed when event_invert is set.
// R3: Mode bit 0 is timer mode, 1 is measure mode and starts counting.
// R4: Clock select gives divide by 2..256, or 111 the external clock edge.
// R5: Software changes clock, pin and gate settings only while stopped.
// R6: Each status flag has its own interrupt enable bit.
// R7: event_pin_en gates the event pin; software sets it before use.
// R8: Gate enable restricts measurement to the chosen gate pin level.
// R9: Bit 0 of the interrupt enable register reads 0, ignores writes.
// R10: Reset leaves the block in timer mode.
// R11: Timer mode counts up while running; wrap sets the wrap flag.
// R12: External count clock pulses last at least 1.5 system cycles.
// R13: Timer mode event edge copies the counter to capture and flags it.
// R14: Timer mode match flag sets when the counter leaves equality with upper limit.
// R15: Measure mode ignores run_ctrl; first edge clears the counter.
// R16: Software stops, clears, loads limits, then enters measure mode.
// R17: Second edge captures and compares against upper and lower limits.
// R18: Third edge clears the counter and starts the next round.
// R19: Clearing the halting limit flag clears the counter and restarts.
// R20: A flag clears only by reading it as 1 then writing 0.
// R21: Each capture moves the old capture value into the buffer.
// R22: Timer mode with run_ctrl 0 holds the counter at zero, no capture.
// R23: Each interrupt output is flag AND enable, held until flag clears.
module cmt_top
	import cmt_pkg::*;
(
	input  wire logic        aclk,          // System clock, 100 MHz
	input  wire logic        aresetn,       // Synchronous reset, active low
	input  wire logic [7:0]  s_awaddr,      // Write address
	input  wire logic        s_awvalid,     // Write address valid
	output var  logic        s_awready,     // Write address ready
	input  wire logic [31:0] s_wdata,       // Write data
	input  wire logic [3:0]  s_wstrb,       // Write byte strobes
	input  wire logic        s_wvalid,      // Write data valid
	output var  logic        s_wready,      // Write data ready
	output var  logic [1:0]  s_bresp,       // Write response
	output var  logic        s_bvalid,      // Write response valid
	input  wire logic        s_bready,      // Write response ready
	input  wire logic [7:0]  s_araddr,      // Read address
	input  wire logic        s_arvalid,     // Read address valid
	output var  logic        s_arready,     // Read address ready
	output var  logic [31:0] s_rdata,       // Read data
	output var  logic [1:0]  s_rresp,       // Read response
	output var  logic        s_rvalid,      // Read data valid
	input  wire logic        s_rready,      // Read data ready
	input  wire logic        event_input,   // Measured event pin
	input  wire logic        gate_input,    // Measurement gate pin
	input  wire logic        ext_clk_input, // External count clock pin
	output var  logic        irq_wrap,      // Counter wrap request
	output var  logic        irq_above,     // Above upper limit request
	output var  logic        irq_match,     // Compare match request
	output var  logic        irq_capture,   // Capture request
	output var  logic        irq_below      // Below lower limit request
);
	cmt_tick_if tif ();

	cmt_word_t  cnt_reg;
	cmt_word_t  upr_reg;
	cmt_word_t  lwr_reg;
	cmt_word_t  cap_reg;
	cmt_word_t  buf_reg;
	logic [7:0] ctl_reg;
	logic [7:0] ien_reg;
	logic [7:0] cfg_reg;
	logic [7:0] flag_reg;
	logic [7:0] arm_reg;
	logic [7:0] irq_reg;
	cmt_phase_t phase_reg;
	logic       halted_reg;
	logic       aw_ok_reg;
	logic       w_ok_reg;
	logic [2:0] aw_idx_reg;
	logic       aw_map_reg;
	logic [31:0] wd_reg;
	logic [3:0] ws_reg;

	logic       mode;
	logic       run;
	logic       t_run;
	logic       meas_act;
	logic       ev_g;
	logic       cnt_inc;
	logic       cap_en;
	logic       wr_do;
	logic       wr_cnt;
	logic       wr_upr;
	logic       wr_sts;
	logic       rd_do;
	logic       lim_hit;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	logic [31:0] rd_mux;

	assign tif.clk_sel        = ctl_reg[2:0];
	assign tif.ext_edge_sel   = cfg_reg[`CMT_B_EXTEDGE];
	assign tif.edge_sel       = ctl_reg[`CMT_B_EDGE];
	assign tif.event_invert   = ctl_reg[`CMT_B_INV];
	assign tif.event_pin_en   = ien_reg[`CMT_B_PINEN];
	assign tif.gate_use_en    = ien_reg[`CMT_B_GATE];
	assign tif.gate_level_sel = cfg_reg[`CMT_B_GLVL];

	cmt_prescale u_pre (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.ext_clk_pin (ext_clk_input),
		.tif         (tif.pre)
	);

	cmt_event_in u_evt (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.event_pin (event_input),
		.gate_pin  (gate_input),
		.tif       (tif.edg)
	);

	function automatic cmt_word_t merge16(cmt_word_t old, logic [31:0] d,
		logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Write side of the register slave
	assign wr_do  = aw_ok_reg & w_ok_reg & ~s_bvalid;
	assign wr_cnt = wr_do & aw_map_reg & (aw_idx_reg == `CMT_IDX_CNT);
	assign wr_upr = wr_do & aw_map_reg & (aw_idx_reg == `CMT_IDX_UPR);
	assign wr_sts = wr_do & aw_map_reg & (aw_idx_reg == `CMT_IDX_STS)
		& ws_reg[0];
	assign rd_do  = s_arvalid & s_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_reg  <= 1'b0;
			s_awready  <= 1'b1;
			aw_idx_reg <= `CMT_IDX_CNT;
			aw_map_reg <= 1'b0;
		end else if (s_awvalid && s_awready) begin
			aw_ok_reg  <= 1'b1;
			s_awready  <= 1'b0;
			aw_idx_reg <= s_awaddr[4:2];
			aw_map_reg <= s_awaddr[7:5] == `CMT_MAP_HI;
		end else if (wr_do) begin
			aw_ok_reg <= 1'b0;
			s_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_ok_reg <= 1'b0;
			s_wready <= 1'b1;
			wd_reg   <= {`CMT_PAD16, `CMT_ZERO16};
			ws_reg   <= 4'h0;
		end else if (s_wvalid && s_wready) begin
			w_ok_reg <= 1'b1;
			s_wready <= 1'b0;
			wd_reg   <= s_wdata;
			ws_reg   <= s_wstrb;
		end else if (wr_do) begin
			w_ok_reg <= 1'b0;
			s_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_bvalid <= 1'b0;
			s_bresp  <= `CMT_RESP_OK;
		end else if (wr_do) begin
			s_bvalid <= 1'b1;
			s_bresp  <= aw_map_reg ? `CMT_RESP_OK : `CMT_RESP_ERR;
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_reg <= `CMT_ZERO8; // R10
			ien_reg <= `CMT_ZERO8;
			cfg_reg <= `CMT_ZERO8;
			upr_reg <= `CMT_UPR_RST;
			lwr_reg <= `CMT_ZERO16;
		end else if (wr_do && aw_map_reg) begin
			unique case (aw_idx_reg)
				`CMT_IDX_CTL: if (ws_reg[0]) ctl_reg <= wd_reg[7:0]; // R3
				`CMT_IDX_IEN: if (ws_reg[0]) begin
					ien_reg <= wd_reg[7:0] & `CMT_IEN_MASK; // R9
				end
				`CMT_IDX_STS: if (ws_reg[0]) begin
					cfg_reg <= wd_reg[7:0] & `CMT_STS_CFG;
				end
				`CMT_IDX_UPR: upr_reg <= merge16(upr_reg, wd_reg, ws_reg);
				`CMT_IDX_LWR: lwr_reg <= merge16(lwr_reg, wd_reg, ws_reg);
				default: ;
			endcase
		end
	end

	// Counter, capture and limit events for both modes
	assign mode     = ctl_reg[`CMT_B_MODE];
	assign run      = ctl_reg[`CMT_B_RUN];
	assign t_run    = ~mode & run; // R22
	assign meas_act = mode & ~halted_reg; // R1 R15
	assign ev_g     = tif.event_edge & tif.gate_ok; // R8
	assign lim_hit  = flag_reg[`CMT_B_ABOVE] | flag_reg[`CMT_B_BELOW];

	always_comb begin
		cnt_inc = tif.count_tick & ((t_run & ~wr_cnt) // R11
			| (meas_act & tif.gate_ok & ~(ev_g & (phase_reg != PH_RUN))));
		cap_en  = (t_run & tif.event_edge) // R13
			| (meas_act & ev_g & (phase_reg == PH_RUN)); // R17
		set_vec = `CMT_ZERO8;
		set_vec[`CMT_B_WRAP]  = cnt_inc & (cnt_reg == `CMT_CNT_MAX); // R11
		set_vec[`CMT_B_MATCH] = ~mode & cnt_inc & ~wr_upr // R14
			& (cnt_reg == upr_reg);
		set_vec[`CMT_B_CAPF]  = cap_en;
		set_vec[`CMT_B_ABOVE] = cap_en & mode & (cnt_reg > upr_reg); // R17
		set_vec[`CMT_B_BELOW] = cap_en & mode & (cnt_reg < lwr_reg); // R17
		clr_vec = wr_sts ? (arm_reg & ~wd_reg[7:0]) : `CMT_ZERO8; // R20
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg   <= `CMT_ZERO16;
			phase_reg <= PH_WAIT;
		end else if (!mode) begin
			phase_reg <= PH_WAIT;
			if (!run) begin
				cnt_reg <= `CMT_ZERO16; // R22
			end else if (wr_cnt) begin
				cnt_reg <= merge16(cnt_reg, wd_reg, ws_reg);
			end else if (cnt_inc) begin
				cnt_reg <= cnt_reg + `CMT_ONE16; // R11
			end
		end else if (halted_reg) begin
			if (!lim_hit) begin
				cnt_reg   <= `CMT_ZERO16; // R19
				phase_reg <= PH_WAIT;
			end
		end else if (ev_g && phase_reg != PH_RUN) begin
			cnt_reg   <= `CMT_ZERO16; // R15 R18
			phase_reg <= PH_RUN;
		end else begin
			if (ev_g) begin
				phase_reg <= PH_HOLD;
			end
			if (cnt_inc) begin
				cnt_reg <= cnt_reg + `CMT_ONE16; // R3 R15
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halted_reg <= 1'b0;
		end else if (!mode || (halted_reg && !lim_hit)) begin
			halted_reg <= 1'b0; // R19
		end else if (ctl_reg[`CMT_B_HALT]
			&& (set_vec[`CMT_B_ABOVE] || set_vec[`CMT_B_BELOW])) begin
			halted_reg <= 1'b1; // R1
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_reg <= `CMT_ZERO16;
			buf_reg <= `CMT_ZERO16;
		end else if (cap_en) begin
			cap_reg <= cnt_reg; // R13 R17
			buf_reg <= cap_reg; // R21
		end
	end

	// Flags: a new event wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_reg <= `CMT_ZERO8;
			arm_reg  <= `CMT_ZERO8;
		end else begin
			flag_reg <= ((flag_reg & ~clr_vec) | set_vec) & `CMT_FLAG_MASK;
			if (rd_do && s_araddr[7:5] == `CMT_MAP_HI
				&& s_araddr[4:2] == `CMT_IDX_STS) begin
				arm_reg <= arm_reg | flag_reg; // R20
			end else begin
				arm_reg <= arm_reg & ~clr_vec & flag_reg;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_reg <= `CMT_ZERO8;
		end else begin
			irq_reg <= flag_reg & ien_reg & `CMT_FLAG_MASK; // R6 R23
		end
	end

	assign irq_wrap    = irq_reg[`CMT_B_WRAP];
	assign irq_above   = irq_reg[`CMT_B_ABOVE];
	assign irq_match   = irq_reg[`CMT_B_MATCH];
	assign irq_capture = irq_reg[`CMT_B_CAPF];
	assign irq_below   = irq_reg[`CMT_B_BELOW];

	// Read side of the register slave
	always_comb begin
		unique case (s_araddr[4:2])
			`CMT_IDX_CNT: rd_mux = {`CMT_PAD16, cnt_reg};
			`CMT_IDX_UPR: rd_mux = {`CMT_PAD16, upr_reg};
			`CMT_IDX_LWR: rd_mux = {`CMT_PAD16, lwr_reg};
			`CMT_IDX_CAP: rd_mux = {`CMT_PAD16, cap_reg};
			`CMT_IDX_BUF: rd_mux = {`CMT_PAD16, buf_reg};
			`CMT_IDX_STS: rd_mux = {`CMT_PAD24, flag_reg | cfg_reg};
			`CMT_IDX_CTL: rd_mux = {`CMT_PAD24, ctl_reg};
			`CMT_IDX_IEN: rd_mux = {`CMT_PAD24, ien_reg};
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= {`CMT_PAD16, `CMT_ZERO16};
			s_rresp   <= `CMT_RESP_OK;
		end else if (rd_do) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			if (s_araddr[7:5] == `CMT_MAP_HI) begin
				s_rdata <= rd_mux;
				s_rresp <= `CMT_RESP_OK;
			end else begin
				s_rdata <= {`CMT_PAD16, `CMT_ZERO16};
				s_rresp <= `CMT_RESP_ERR;
			end
		end else if (s_rvalid && s_rready) begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_reset_timer_mode: assert property ( // R10
		!$past(aresetn) |-> !ctl_reg[`CMT_B_MODE])
		else $error("not in timer mode after reset");
	a_stop_clears_cnt: assert property ( // R22
		(!mode && !run) |=> cnt_reg == `CMT_ZERO16)
		else $error("stopped counter not zero");
	a_wrap_sets_flag: assert property ( // R11
		(cnt_inc && cnt_reg == `CMT_CNT_MAX) |=> flag_reg[`CMT_B_WRAP])
		else $error("wrap flag missed");
	a_match_sets_flag: assert property ( // R14
		(set_vec[`CMT_B_MATCH]) |=> flag_reg[`CMT_B_MATCH]
		&& cnt_reg == $past(upr_reg) + `CMT_ONE16)
		else $error("match flag wrong");
	a_capture_copies: assert property ( // R13
		cap_en |=> cap_reg == $past(cnt_reg) && flag_reg[`CMT_B_CAPF])
		else $error("capture value wrong");
	a_buffer_moves: assert property ( // R21
		cap_en |=> buf_reg == $past(cap_reg))
		else $error("capture buffer not updated");
	a_above_limit: assert property ( // R17
		(cap_en && mode && cnt_reg > upr_reg) |=> flag_reg[`CMT_B_ABOVE])
		else $error("above limit flag missed");
	a_first_edge_clear: assert property ( // R15
		(meas_act && ev_g && phase_reg != PH_RUN) |=> cnt_reg == `CMT_ZERO16)
		else $error("first edge did not clear");
	a_halt_holds: assert property ( // R1
		(mode && halted_reg && lim_hit) |=> cnt_reg == $past(cnt_reg)
		&& !$rose(flag_reg[`CMT_B_CAPF]))
		else $error("halted counter moved");
	a_halt_restart: assert property ( // R19
		(mode && halted_reg && !lim_hit) |=> cnt_reg == `CMT_ZERO16
		&& phase_reg == PH_WAIT && !halted_reg)
		else $error("restart after halt failed");
	a_irq_follows: assert property ( // R23
		(flag_reg[`CMT_B_WRAP] && ien_reg[`CMT_B_WRAP]) [*2]
		|-> irq_wrap)
		else $error("wrap request not held");
	a_ien_reserved: assert property ( // R9
		ien_reg[`CMT_B_RSV] == 1'b0)
		else $error("reserved enable bit set");

	c_wrap: cover property (set_vec[`CMT_B_WRAP]);
	c_measure_cap: cover property (cap_en && mode);
	c_halt: cover property ($rose(halted_reg));
	c_below: cover property (set_vec[`CMT_B_BELOW] && irq_below);
endmodule // cmt_top
`default_nettype wire

// File: verification/cmt_wave_src.sv
// Event waveform and external count clock source for the period timer
`default_nettype none
module cmt_wave_src #(
	parameter int HI       = 128,
	parameter int LO       = 384,
	parameter int EXT_HALF = 4
) (
	input  wire logic aclk,        // System clock
	input  wire logic run,         // Waveform on, low holds the pin low
	output var  logic event_out,   // Event pin level
	output var  logic ext_clk_out  // Free running external count clock
);
	timeunit 1ns;
	timeprecision 1ns;
	int ev_cnt = 0;
	int ck_cnt = 0;
	initial event_out = 1'b0;
	initial ext_clk_out = 1'b0;
	// Asymmetric duty lets the bench tell rising from falling captures
	always @(posedge aclk) begin
		ev_cnt <= (!run || ev_cnt == HI + LO - 1) ? 0 : ev_cnt + 1;
		event_out <= run && (ev_cnt < HI);
	end
	// Each half lasts EXT_HALF system cycles, well above the minimum width
	always @(posedge aclk) begin
		ck_cnt <= (ck_cnt == EXT_HALF - 1) ? 0 : ck_cnt + 1;
		if (ck_cnt == EXT_HALF - 1) begin
			ext_clk_out <= !ext_clk_out;
		end
	end
endmodule // cmt_wave_src
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the period timer over its register bus
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata   = 32'h00000000;
	logic        wvalid  = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready  = 1'b0;
	logic [7:0]  araddr  = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready  = 1'b0;
	logic        ev;
	logic        ext_ck;
	logic        gate    = 1'b1;
	logic        src_run = 1'b0;
	logic [4:0]  irq;
	logic [31:0] c1;
	logic [31:0] rd;
	logic [1:0]  rs;
	int          fails      = 0;
	int          n_compared = 0;
	int          cyc        = 0;
	int          div [8]    = '{2, 8, 16, 32, 64, 128, 256, 8};

	always #5 aclk = !aclk;

	cmt_wave_src u_src (.aclk(aclk), .run(src_run), .event_out(ev),
		.ext_clk_out(ext_ck));

	cmt_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
		.s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
		.s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
		.s_rready(rready), .event_input(ev), .gate_input(gate),
		.ext_clk_input(ext_ck), .irq_wrap(irq[4]), .irq_above(irq[3]),
		.irq_match(irq[2]), .irq_capture(irq[1]), .irq_below(irq[0]));

	task automatic report_and_stop;
		if (fails == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails = fails + 1;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta;
		logic tw;
		logic tb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta;
		logic done;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid && arready;
			done = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end while (!done);
		rready <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd_reg(a, d, r);
		check(d, e);
	endtask

	// Read status, then write zeros to the flags, keeping the external edge
	task automatic clr_sts;
		logic [31:0] d;
		logic [1:0]  r;
		rd_reg(8'h14, d, r);
		wr(8'h14, 32'h00000010);
	endtask

	task automatic wait_irq(input int i);
		int n;
		n = 0;
		// Step past the current edge so a request dropping there is seen
		do begin
			@(negedge aclk);
			n++;
		end while (irq[i] !== 1'b1 && n < 3000);
		if (irq[i] !== 1'b1) begin
			fails++;
			$display("unexpected at %0t: no request on line %0d", $time, i);
		end
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		src_run <= 1'b1;
		rchk(8'h18, 32'h00000000);
		rchk(8'h04, 32'h0000FFFF);
		wr(8'h1C, 32'h000000FF);
		rchk(8'h1C, 32'h000000FE);
		rd_reg(8'h40, rd, rs);
		check({30'h0, rs}, 32'h00000002);
		// Pin gated off: running timer sees no capture
		wr(8'h1C, 32'h00000008);
		wr(8'h18, 32'h00000080);
		repeat (1200) @(posedge aclk);
		rchk(8'h14, 32'h00000000);
		// Wrap and match, flags held until read then cleared
		wr(8'h18, 32'h00000000);
		wr(8'h04, 32'h0000FFF8);
		wr(8'h1C, 32'h000000A0);
		wr(8'h18, 32'h00000080);
		wr(8'h00, 32'h0000FFF0);
		repeat (100) @(posedge aclk);
		wr(8'h18, 32'h00000000);
		rchk(8'h00, 32'h00000000);
		wr(8'h14, 32'h00000000);
		rchk(8'h14, 32'h000000A0);
		check(irq, 32'h00000014);
		wr(8'h14, 32'h000000FF);
		rchk(8'h14, 32'h000000B2);
		wr(8'h14, 32'h00000010);
		rchk(8'h14, 32'h00000010);
		check(irq, 32'h00000000);
		// Every clock select with rotating edge choices
		wr(8'h1C, 32'h00000018);
		for (int i = 0; i < 8; i++) begin
			wr(8'h18, {24'h0, 1'b0, i[1], 1'b0, i[0], 1'b0, i[2:0]});
			wr(8'h18, {24'h0, 1'b1, i[1], 1'b0, i[0], 1'b0, i[2:0]});
			clr_sts();
			wait_irq(1);
			check(ev, i[0] == i[1]);
			clr_sts();
			wait_irq(1);
			rd_reg(8'h0C, c1, rs);
			rd_reg(8'h10, rd, rs);
			check(c1 - rd, 512 / div[i]);
			wr(8'h18, {24'h0, 1'b0, i[1], 1'b0, i[0], 1'b0, i[2:0]});
		end
		// Measurement held off by the gate level, halt on limit
		wr(8'h18, 32'h00000000);
		clr_sts();
		wr(8'h1C, 32'h00000056);
		wr(8'h04, 32'h00000096);
		wr(8'h08, 32'h00000032);
		wr(8'h18, 32'h00000028);
		repeat (1500) @(posedge aclk);
		rchk(8'h14, 32'h00000010);
		@(posedge aclk);
		gate <= 1'b0;
		wait_irq(3);
		rd_reg(8'h0C, c1, rs);
		check(c1 >= 255 && c1 <= 256, 32'h00000001);
		rd_reg(8'h00, c1, rs);
		repeat (100) @(posedge aclk);
		rchk(8'h00, c1);
		clr_sts();
		rd_reg(8'h00, rd, rs);
		check(rd < 16, 32'h00000001);
		// No halt: below limit flagged while counting goes on
		wr(8'h08, 32'h0000012C);
		wr(8'h18, 32'h00000008);
		wait_irq(0);
		check(irq[0], 32'h00000001);
		rd_reg(8'h00, c1, rs);
		repeat (20) @(posedge aclk);
		rd_reg(8'h00, rd, rs);
		check(c1 !== rd, 32'h00000001);
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
